// File: verilog/pwm_consts.vh
`ifndef PWM_CONSTS_VH
`define PWM_CONSTS_VH
// ==========================================================
// register byte addresses
`define ADDR_CLOCK_GATE 16'h0016
`define ADDR_PIN_CLOCK_CTRL 16'h0370
`define ADDR_CH0_PRESCALE 16'h0372
`define ADDR_CH0_DUTY 16'h0373
`define ADDR_CH1_PRESCALE 16'h0374
`define ADDR_CH1_DUTY 16'h0375
`define ADDR_OUTPUT_CTRL 16'h0376
// ==========================================================
// field positions
`define BIT_CLOCK_STOP 6
`define BIT_CH0_SEL 0
`define BIT_CH1_SEL 1
`define BIT_SRC_LO 6
`define BIT_SRC_HI 7
`define BIT_CH0_EN 0
`define BIT_CH1_EN 1
`define BIT_CH0_PORT 2
`define BIT_CH1_PORT 3
// ==========================================================
// reset values and counts
`define RST_BYTE 8'h00
`define PERIOD_LAST 8'hfe
`define CLOCK_GATE_MASK 8'h7f
`define PIN_CLOCK_MASK 8'hc3
`define OUTPUT_CTRL_MASK 8'h0f
`endif

// File: verilog/pwm_channel.v
`timescale 1ns/1ps
`include "pwm_consts.vh"
// ==========================================================
// one modulator channel
module pwm_channel (
  input wire clk,
  input wire rst,
  input wire tick,
  input wire enable,
  input wire pre_wr,
  input wire duty_wr,
  input wire [7:0] wr_data,
  output wire [7:0] pre_prelatch,
  output wire [7:0] duty_latch,
  output reg wave_q
);
  reg [7:0] pre_pl_q;
  reg [7:0] duty_pl_q;
  reg [7:0] pre_latch_q;
  reg [7:0] duty_latch_q;
  reg [7:0] pre_cnt_q;
  reg [7:0] period_cnt_q;
  reg running_q;
  wire step;
  wire period_end;
  assign pre_prelatch = pre_pl_q;
  assign duty_latch = duty_latch_q;
  assign step = tick && (pre_cnt_q == 8'h00);
  assign period_end = step && (period_cnt_q == `PERIOD_LAST);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_pl_q <= `RST_BYTE;
      duty_pl_q <= `RST_BYTE;
      pre_latch_q <= `RST_BYTE;
      duty_latch_q <= `RST_BYTE;
      pre_cnt_q <= `RST_BYTE;
      period_cnt_q <= `RST_BYTE;
      running_q <= 1'b0;
      wave_q <= 1'b0; // see R11
    end else begin
      if (pre_wr)
        pre_pl_q <= wr_data; // see R5
      if (duty_wr)
        duty_pl_q <= wr_data; // see R6
      if (!enable) begin
        running_q <= 1'b0; // hold level and latches, see R10
      end else if (!running_q) begin
        // start on a tick so the first state is a whole (m+1) ticks long
        if (tick) begin
          // first period after enable keeps old latches, see R7
          running_q <= 1'b1;
          pre_cnt_q <= pre_latch_q;
          period_cnt_q <= 8'h00;
        end
      end else if (tick) begin
        if (pre_cnt_q != 8'h00) begin
          pre_cnt_q <= pre_cnt_q - 8'h01;
        end else begin
          pre_cnt_q <= pre_latch_q; // (m+1) ticks per step, see R3
          if (period_end) begin
            period_cnt_q <= 8'h00; // 255 states, see R19
            pre_latch_q <= pre_pl_q; // see R5
            pre_cnt_q <= pre_pl_q;
            duty_latch_q <= duty_pl_q; // see R6
          end else begin
            period_cnt_q <= period_cnt_q + 8'h01;
          end
        end
      end
      if (enable && running_q)
        wave_q <= (period_cnt_q < duty_latch_q); // see R4 R19
    end
  end
endmodule // pwm_channel

// File: verilog/pwm_top.v
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`include "pwm_consts.vh"
// Behaviour
// R1: two independent channels, 8-bit duty
// R2: bits 7..6 select clock /2 /4 /8 /16
// R3: period is 255 times (prescale+1) ticks
// R4: high for (prescale+1) times duty ticks
// R5: prescale write loads prelatch, applies next period
// R6: duty write loads prelatch, applies next period
// R7: first period after enable uses old values
// R8: disabled reads return prescale prelatch, duty latch
// R9: enabled reads are undefined
// R10: disable holds output level and values
// R11: outputs low right after reset
// R12: pin select bits route to first/second pin
// R13: port switch bits give pin to modulator
// R14: enable bits start channel pulse output
// R15: change select and source only while disabled
// R16: clear clock stop bit before use
// R17: unlock protection before clock stop write; there is no lock here, the clock stop bit is always writable
// R18: software start order: port, select, values, enable
// R19: period counter below duty drives high
// R20: reserved control bits ignored, read zero
module pwm_top (
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [15:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire wb_err_o,
  output reg ch0_first_pin,
  output reg ch0_first_pin_oe,
  output reg ch0_second_pin,
  output reg ch0_second_pin_oe,
  output reg ch1_first_pin,
  output reg ch1_first_pin_oe,
  output reg ch1_second_pin,
  output reg ch1_second_pin_oe
);
  // ==========================================================
  // register bus
  reg [7:0] peripheral_clock_gate_q;
  reg [7:0] pwm_pin_clock_ctrl_q;
  reg [7:0] pwm_output_ctrl_q;
  reg [3:0] div_q;
  wire req;
  wire wr;
  wire [15:0] word_adr;
  wire [1:0] lane;
  wire [7:0] wr_byte;
  wire lane_ok;
  wire clock_run;
  wire tick;
  wire ch0_en;
  wire ch1_en;
  wire [7:0] ch0_pre;
  wire [7:0] ch0_duty;
  wire [7:0] ch1_pre;
  wire [7:0] ch1_duty;
  wire ch0_wave;
  wire ch1_wave;
  reg [7:0] rd_byte;
  wire sel_clock_gate;
  wire sel_pin_clock;
  wire sel_ch0_pre;
  wire sel_ch0_duty;
  wire sel_ch1_pre;
  wire sel_ch1_duty;
  wire sel_output_ctrl;
  wire wr_clock_gate;
  wire wr_pin_clock;
  wire wr_ch0_pre;
  wire wr_ch0_duty;
  wire wr_ch1_pre;
  wire wr_ch1_duty;
  wire wr_output_ctrl;
  wire [1:0] src_sel;
  wire ch0_sel;
  wire ch1_sel;
  wire ch0_port;
  wire ch1_port;
  wire ch0_first_oe_d;
  wire ch0_second_oe_d;
  wire ch1_first_oe_d;
  wire ch1_second_oe_d;

  // each 8-bit register sits in its own byte lane of the aligned word
  function [7:0] pick_byte;
    input [31:0] word;
    input [1:0] sel;
    begin
      case (sel)
        2'd0: pick_byte = word[7:0];
        2'd1: pick_byte = word[15:8];
        2'd2: pick_byte = word[23:16];
        default: pick_byte = word[31:24];
      endcase
    end
  endfunction

  function is_addr;
    input [15:0] a;
    input [15:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  // reserved and absent bits are stored as zero so they read back zero
  function [7:0] keep_bits;
    input [7:0] v;
    input [7:0] m;
    begin
      keep_bits = v & m;
    end
  endfunction

  // tick decode for the shared count source: one clock in 2, 4, 8 or 16
  function src_tick;
    input [1:0] src;
    input [3:0] div;
    begin
      case (src)
        2'd0: src_tick = div[0];
        2'd1: src_tick = (div[1:0] == 2'h3);
        2'd2: src_tick = (div[2:0] == 3'h7);
        default: src_tick = (div == 4'hf);
      endcase
    end
  endfunction

  // a pin is driven only with the port switch set and the select pointing at it
  function pin_owned;
    input port_sw;
    input pin_sel;
    input want_second;
    begin
      pin_owned = port_sw && (pin_sel == want_second);
    end
  endfunction

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign lane = wb_adr_i[1:0];
  assign word_adr = wb_adr_i;
  assign wr_byte = pick_byte(wb_dat_i, lane);
  assign lane_ok = wb_sel_i[lane];
  assign wr = req && wb_we_i && lane_ok;
  assign wb_err_o = 1'b0;

  // ==========================================================
  // address decode
  assign sel_clock_gate = is_addr(word_adr, `ADDR_CLOCK_GATE);
  assign sel_pin_clock = is_addr(word_adr, `ADDR_PIN_CLOCK_CTRL);
  assign sel_ch0_pre = is_addr(word_adr, `ADDR_CH0_PRESCALE);
  assign sel_ch0_duty = is_addr(word_adr, `ADDR_CH0_DUTY);
  assign sel_ch1_pre = is_addr(word_adr, `ADDR_CH1_PRESCALE);
  assign sel_ch1_duty = is_addr(word_adr, `ADDR_CH1_DUTY);
  assign sel_output_ctrl = is_addr(word_adr, `ADDR_OUTPUT_CTRL);
  assign wr_clock_gate = wr && sel_clock_gate;
  assign wr_pin_clock = wr && sel_pin_clock;
  assign wr_ch0_pre = wr && sel_ch0_pre;
  assign wr_ch0_duty = wr && sel_ch0_duty;
  assign wr_ch1_pre = wr && sel_ch1_pre;
  assign wr_ch1_duty = wr && sel_ch1_duty;
  assign wr_output_ctrl = wr && sel_output_ctrl;
  assign src_sel = pwm_pin_clock_ctrl_q[`BIT_SRC_HI:`BIT_SRC_LO];
  assign ch0_sel = pwm_pin_clock_ctrl_q[`BIT_CH0_SEL];
  assign ch1_sel = pwm_pin_clock_ctrl_q[`BIT_CH1_SEL];
  assign ch0_port = pwm_output_ctrl_q[`BIT_CH0_PORT];
  assign ch1_port = pwm_output_ctrl_q[`BIT_CH1_PORT];

  // unmapped addresses read zero
  always @* begin
    rd_byte = 8'h00;
    if (sel_clock_gate)
      rd_byte = peripheral_clock_gate_q;
    else if (sel_pin_clock)
      rd_byte = pwm_pin_clock_ctrl_q; // see R20
    else if (sel_ch0_pre)
      rd_byte = ch0_pre; // see R8 R9
    else if (sel_ch0_duty)
      rd_byte = ch0_duty; // see R8
    else if (sel_ch1_pre)
      rd_byte = ch1_pre; // see R8 R9
    else if (sel_ch1_duty)
      rd_byte = ch1_duty; // see R8
    else if (sel_output_ctrl)
      rd_byte = pwm_output_ctrl_q;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      peripheral_clock_gate_q <= `RST_BYTE;
      pwm_pin_clock_ctrl_q <= `RST_BYTE;
      pwm_output_ctrl_q <= `RST_BYTE;
    end else begin
      // unmapped addresses ack and read zero, writes dropped
      wb_ack_o <= req;
      if (req && !wb_we_i)
        wb_dat_o <= {rd_byte, rd_byte, rd_byte, rd_byte};
      if (wr_clock_gate)
        peripheral_clock_gate_q <= keep_bits(wr_byte, `CLOCK_GATE_MASK);
      if (wr_pin_clock)
        pwm_pin_clock_ctrl_q <= keep_bits(wr_byte, `PIN_CLOCK_MASK); // see R20
      if (wr_output_ctrl)
        pwm_output_ctrl_q <= keep_bits(wr_byte, `OUTPUT_CTRL_MASK);
    end
  end

  // ==========================================================
  // shared count source
  // stopping the base clock freezes the divider and all channels
  assign clock_run = !peripheral_clock_gate_q[`BIT_CLOCK_STOP];

  always @(posedge clk or posedge rst) begin
    if (rst)
      div_q <= 4'h0;
    else if (clock_run)
      div_q <= div_q + 4'h1;
  end

  // one tick each 2, 4, 8 or 16 clocks, see R2
  assign tick = clock_run && src_tick(src_sel, div_q); // see R2

  // ==========================================================
  // channels
  assign ch0_en = pwm_output_ctrl_q[`BIT_CH0_EN] && clock_run; // see R14
  assign ch1_en = pwm_output_ctrl_q[`BIT_CH1_EN] && clock_run; // see R14

  // two separate instances keep the channels independent, see R1
  pwm_channel u_ch0 (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .enable(ch0_en),
    .pre_wr(wr_ch0_pre),
    .duty_wr(wr_ch0_duty),
    .wr_data(wr_byte),
    .pre_prelatch(ch0_pre),
    .duty_latch(ch0_duty),
    .wave_q(ch0_wave)
  );

  pwm_channel u_ch1 (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .enable(ch1_en),
    .pre_wr(wr_ch1_pre),
    .duty_wr(wr_ch1_duty),
    .wr_data(wr_byte),
    .pre_prelatch(ch1_pre),
    .duty_latch(ch1_duty),
    .wave_q(ch1_wave)
  );

  // ==========================================================
  // pin routing
  // oe low leaves the pin to the general port logic outside
  assign ch0_first_oe_d = pin_owned(ch0_port, ch0_sel, 1'b0); // see R12 R13
  assign ch0_second_oe_d = pin_owned(ch0_port, ch0_sel, 1'b1); // see R12 R13
  assign ch1_first_oe_d = pin_owned(ch1_port, ch1_sel, 1'b0); // see R12 R13
  assign ch1_second_oe_d = pin_owned(ch1_port, ch1_sel, 1'b1); // see R12 R13

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ch0_first_pin <= 1'b0;
      ch0_first_pin_oe <= 1'b0;
      ch0_second_pin <= 1'b0;
      ch0_second_pin_oe <= 1'b0;
      ch1_first_pin <= 1'b0;
      ch1_first_pin_oe <= 1'b0;
      ch1_second_pin <= 1'b0;
      ch1_second_pin_oe <= 1'b0;
    end else begin
      ch0_first_pin <= ch0_wave;
      ch0_second_pin <= ch0_wave;
      ch1_first_pin <= ch1_wave;
      ch1_second_pin <= ch1_wave;
      ch0_first_pin_oe <= ch0_first_oe_d;
      ch0_second_pin_oe <= ch0_second_oe_d;
      ch1_first_pin_oe <= ch1_first_oe_d;
      ch1_second_pin_oe <= ch1_second_oe_d;
    end
  end
endmodule // pwm_top

// File: sim/pwm_top_asserts.sv
`timescale 1ns/1ps
// ==========================================================
// port checker
module pwm_top_asserts (
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire wb_err_o,
  input wire ch0_first_pin,
  input wire ch0_first_pin_oe,
  input wire ch0_second_pin,
  input wire ch0_second_pin_oe,
  input wire ch1_first_pin,
  input wire ch1_first_pin_oe,
  input wire ch1_second_pin,
  input wire ch1_second_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ack_one_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  err_quiet_a: assert property (!wb_err_o) else $error("err raised");
  ch0_pin_excl_a: assert property (!(ch0_first_pin_oe && ch0_second_pin_oe))
    else $error("ch0 on two pins");
  ch1_pin_excl_a: assert property (!(ch1_first_pin_oe && ch1_second_pin_oe))
    else $error("ch1 on two pins");
  ch0_copies_a: assert property (ch0_first_pin == ch0_second_pin)
    else $error("ch0 copies differ");
  ch1_copies_a: assert property (ch1_first_pin == ch1_second_pin)
    else $error("ch1 copies differ");
  reset_low_a: assert property ($fell(rst) |-> !ch0_first_pin && !ch1_first_pin)
    else $error("wave high after reset");
endmodule // pwm_top_asserts
bind pwm_top pwm_top_asserts pwm_top_asserts_i (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .ch0_first_pin(ch0_first_pin), .ch0_first_pin_oe(ch0_first_pin_oe),
  .ch0_second_pin(ch0_second_pin), .ch0_second_pin_oe(ch0_second_pin_oe),
  .ch1_first_pin(ch1_first_pin), .ch1_first_pin_oe(ch1_first_pin_oe),
  .ch1_second_pin(ch1_second_pin), .ch1_second_pin_oe(ch1_second_pin_oe));

// File: sim/pin_load.sv
`timescale 1ns/1ps
// ==========================================================
// external load: an undriven pin falls to its pull-down, never keeps the last level
module pin_load (
  input wire [3:0] lvl,
  input wire [3:0] oe,
  output wire [3:0] pad
);
  assign pad = oe & lvl;
endmodule // pin_load

// File: sim/test_dual_channel_8bit_pwm.sv
`timescale 1ns/1ps
`include "pwm_consts.vh"
module test_dual_channel_8bit_pwm;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg cyc = 1'b0;
  reg we = 1'b0;
  reg [15:0] adr = 16'h0000;
  reg [31:0] wdat = 32'h00000000;
  reg [7:0] got;
  wire [31:0] rdat;
  wire ack;
  wire [3:0] lvl;
  wire [3:0] oe;
  wire [3:0] pad;
  integer n_fail = 0;
  integer checked = 0;
  integer cycles = 0;
  integer i;
  integer h;
  // ==========================================================
  // harness
  pwm_top pwm_top_i (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(), .ch0_first_pin(lvl[0]), .ch0_first_pin_oe(oe[0]), .ch0_second_pin(lvl[1]),
    .ch0_second_pin_oe(oe[1]), .ch1_first_pin(lvl[2]), .ch1_first_pin_oe(oe[2]),
    .ch1_second_pin(lvl[3]), .ch1_second_pin_oe(oe[3]));
  pin_load pin_load_i (.lvl(lvl), .oe(oe), .pad(pad));
  initial begin
    forever #25 clk = ~clk;
  end
  // ==========================================================
  // shared tasks
  task give_verdict;
    begin
      if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task check(input [31:0] g, input [31:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  // request held until ack is sampled; cyc then drops for a cycle before the next one
  task wb(input w, input [15:0] a, input [7:0] d);
    begin
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {4{d}};
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      got = rdat[7:0];
      cyc <= 1'b0;
    end
  endtask
  task rd(input [15:0] a, input [7:0] e);
    begin
      wb(1'b0, a, 8'h00);
      check({24'h0, got}, {24'h0, e});
    end
  endtask
  // measures one whole rise-to-rise period, so phase at entry does not matter
  task wave(input integer k, input integer hi, input integer per);
    integer p;
    begin
      while (pad[k] !== 1'b0) @(posedge clk);
      while (pad[k] !== 1'b1) @(posedge clk);
      p = 0;
      while (pad[k] === 1'b1) begin
        p = p + 1;
        @(posedge clk);
      end
      check(p, hi);
      while (pad[k] === 1'b0) begin
        p = p + 1;
        @(posedge clk);
      end
      check(p, per);
    end
  endtask
  // ==========================================================
  // scenarios
  task t_reset;
    begin
      check({28'h0, pad}, 32'h0);
      rd(`ADDR_CLOCK_GATE, 8'h00);
      for (i = 0; i < 8; i = i + 1) rd(16'h0370 + i[15:0], 8'h00);
    end
  endtask
  task t_regs;
    begin
      wb(1'b1, `ADDR_PIN_CLOCK_CTRL, 8'hff);
      rd(`ADDR_PIN_CLOCK_CTRL, 8'hc3);
      wb(1'b1, `ADDR_CLOCK_GATE, 8'hbf);
      rd(`ADDR_CLOCK_GATE, 8'h3f);
      wb(1'b1, `ADDR_PIN_CLOCK_CTRL, 8'h00);
      wb(1'b1, `ADDR_CH0_PRESCALE, 8'h05);
      wb(1'b1, `ADDR_CH0_DUTY, 8'h02);
      rd(`ADDR_CH0_PRESCALE, 8'h05);
      rd(`ADDR_CH0_DUTY, 8'h00);
      wb(1'b1, `ADDR_CH0_PRESCALE, 8'h00);
    end
  endtask
  task t_wave0;
    begin
      wb(1'b1, `ADDR_OUTPUT_CTRL, 8'h05);
      h = 0;
      for (i = 0; i < 500; i = i + 1) begin
        @(posedge clk);
        if (pad[0] !== 1'b0) h = h + 1;
      end
      check(h, 0);
      check({28'h0, oe}, 32'h1);
      wave(0, 4, 510);
      repeat (10) @(posedge clk);
      wb(1'b1, `ADDR_OUTPUT_CTRL, 8'h04);
      h = 0;
      for (i = 0; i < 600; i = i + 1) begin
        @(posedge clk);
        if (lvl[0] !== 1'b0) h = h + 1;
      end
      check(h, 0);
    end
  endtask
  task t_src;
    begin
      wb(1'b1, `ADDR_PIN_CLOCK_CTRL, 8'hc0);
      wb(1'b1, `ADDR_CH0_PRESCALE, 8'h01);
      wb(1'b1, `ADDR_CH0_DUTY, 8'h03);
      wb(1'b1, `ADDR_OUTPUT_CTRL, 8'h05);
      wave(0, 32, 4080);
      wave(0, 96, 8160);
    end
  endtask
  task t_ch1;
    begin
      for (i = 1; i < 3; i = i + 1) begin
        wb(1'b1, `ADDR_OUTPUT_CTRL, 8'h00);
        repeat (2) @(posedge clk);
        check({28'h0, oe}, 32'h0);
        wb(1'b1, `ADDR_PIN_CLOCK_CTRL, {i[1:0], 6'h02});
        wb(1'b1, `ADDR_CH1_DUTY, 8'h01);
        wb(1'b1, `ADDR_OUTPUT_CTRL, 8'h0a);
        repeat (2) @(posedge clk);
        check({28'h0, oe}, 32'h8);
        wave(3, 2 << i, 255 * (2 << i));
      end
    end
  endtask
  // ==========================================================
  // sequence and hang guard
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 45000) begin
      n_fail = n_fail + 1;
      give_verdict;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_regs;
    t_wave0;
    t_src;
    t_ch1;
    give_verdict;
  end
endmodule // test_dual_channel_8bit_pwm
